// File: src/fmc_flash_ctrl.sv
// Purpose: Flash ROM access port, flash control registers and operating mode control.
// Assumes: All inputs are synchronous to clock; the CPU port issues one request at a time.
// Notes: The array has no reset; its contents are undefined until erased.
//
// How it works
// - The ROM array reaches the CPU over a 16-bit data path.
// - Byte and word reads of the ROM finish in two clock states.
// - Even-address bytes use data lines 15..8, odd-address bytes lines 7..0.
// - Mode pins hi=0, lo=1 give expanded mode with the ROM disabled.
// - Mode pins hi=1, lo=0 and single-chip mode enable the ROM.
// - ROM enable follows both mode pins only, not the expanded-mode bit.
// - Four flash modes exist: program, program-verify, erase, erase-verify.
// - A program operation writes a 32-byte group at once.
// - In boot mode the serial bit rate is measured from the host.
// - Hardware, software and error protection block program, erase and verify.
// - The flash select bit routes shared addresses to the flash registers.
// - With the ROM disabled, flash registers ignore writes and read zero.
// - While software write enable is clear, control two and erase select hold zero.
// - Expanded-mode bit is one in mode 1, starts zero in modes 2 and 3.
// - Expanded-mode bit is writable only in boot mode; one means expanded.
// - Mode control bits 6,5,2 read one, bits 4,3 read zero, writes ignored.
// - Mode status bits copy the mode pins at the moment of the read.
// - In user mode the flash reads but program and erase are refused.
// - Erase needs write enables and erase setup; program needs enable and setup.
`timescale 1ns/1ns
module fmc_flash_ctrl #(
    parameter int ROM_WORDS = 30720,
    parameter int BAUD_W = 20
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // Avalon-MM register slave
    input wire logic [17:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // Mode pins and on-board programming mode
    input wire logic mode_pin_hi,
    input wire logic mode_pin_lo,
    input wire logic boot_mode,
    input wire logic user_program_mode,
    // CPU ROM port
    input wire logic rom_req,
    input wire logic rom_we,
    input wire logic rom_word,
    input wire logic [15:0] rom_addr,
    input wire logic [15:0] rom_wdata,
    output logic [15:0] rom_rdata,
    output logic rom_ack,
    // Boot serial receive line
    input wire logic boot_rxd,
    // Status
    output logic rom_enabled,
    output logic expanded_mode,
    output fmc_pkg::fmc_op_e op_mode,
    output logic hw_protect,
    output logic sw_protect,
    output logic err_protect,
    output logic [BAUD_W-1:0] baud_period,
    output logic baud_locked
);
    import fmc_pkg::*;

    localparam int AW = $clog2(ROM_WORDS);

    // ===========================================================
    // Mode decode
    logic mode1_c;
    logic rom_en_c;
    logic prot_hw_c;
    assign mode1_c = !mode_pin_hi && mode_pin_lo;
    assign rom_en_c = !mode1_c;
    // Outside boot and user programming the part is in user mode and may only read.
    assign prot_hw_c = !rom_en_c || !(boot_mode || user_program_mode);

    // ===========================================================
    // Avalon slave: one wait state, write committed on the low-waitrequest edge
    logic wait_q;
    logic take_c;
    logic commit_c;
    logic [15:0] idx_c;
    logic [7:0] wd_c;
    assign take_c = (avs_read || avs_write) && wait_q;
    assign commit_c = avs_write && !wait_q && avs_byteenable[0];
    assign idx_c = avs_address[17:2];
    assign wd_c = avs_writedata[7:0];

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            wait_q <= 1'b1;
        end else begin
            wait_q <= !((avs_read || avs_write) && wait_q);
        end
    end
    assign avs_waitrequest = wait_q;

    // ===========================================================
    // Control registers
    logic swe_q, ev_q, pv_q, e_q, p_q;
    logic esu_q, psu_q, fler_q;
    logic [7:0] ebr_q;
    logic [7:0] wait_state_control_q;
    logic expanded_mode_enable_q;
    logic init_q;
    logic flash_acc_c;
    logic wr_c1, wr_c2, wr_ebr, wr_md;
    logic clr_modes_c;
    logic fler_set_c;
    logic commit_prog_c;

    // Flash registers are reachable only with the ROM enabled and the select bit set.
    assign flash_acc_c = rom_en_c && wait_state_control_q[FMC_WS_FLASH_SEL];
    assign wr_c1 = commit_c && flash_acc_c && idx_c == FMC_IDX_CTRL_ONE;
    assign wr_c2 = commit_c && flash_acc_c && idx_c == FMC_IDX_CTRL_TWO;
    assign wr_ebr = commit_c && flash_acc_c && idx_c == FMC_IDX_ERASE_BLK;
    assign wr_md = commit_c && idx_c == FMC_IDX_MODE_CTRL;
    assign clr_modes_c = !swe_q || prot_hw_c || fler_q;
    assign commit_prog_c = wr_c1 && !clr_modes_c && psu_q && wd_c[FMC_C1_P] && !p_q;

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            swe_q <= FMC_CTRL_ONE_RST[FMC_C1_SWE];
        end else if (wr_c1) begin
            swe_q <= wd_c[FMC_C1_SWE];
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            ev_q <= 1'b0;
            pv_q <= 1'b0;
        end else if (clr_modes_c) begin
            ev_q <= 1'b0;
            pv_q <= 1'b0;
        end else if (wr_c1) begin
            ev_q <= wd_c[FMC_C1_EV];
            pv_q <= wd_c[FMC_C1_PV];
        end
    end

    // The write enable bit of control one is fixed at one, so only the setup bits gate.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            e_q <= 1'b0;
            p_q <= 1'b0;
        end else if (clr_modes_c) begin
            e_q <= 1'b0;
            p_q <= 1'b0;
        end else if (wr_c1) begin
            if (FMC_CTRL_ONE_RST[FMC_C1_FWE] && esu_q) begin
                e_q <= wd_c[FMC_C1_E];
            end
            if (psu_q) begin
                p_q <= wd_c[FMC_C1_P];
            end
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            esu_q <= FMC_CTRL_TWO_RST[FMC_C2_ESU];
            psu_q <= FMC_CTRL_TWO_RST[FMC_C2_PSU];
        end else if (clr_modes_c) begin
            esu_q <= 1'b0;
            psu_q <= 1'b0;
        end else if (wr_c2) begin
            esu_q <= wd_c[FMC_C2_ESU];
            psu_q <= wd_c[FMC_C2_PSU];
        end
    end

    // An array read during program or erase is an error; the set wins over the clear.
    assign fler_set_c = rom_req && !rom_we && (p_q || e_q);
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            fler_q <= FMC_CTRL_TWO_RST[FMC_C2_FLER];
        end else begin
            fler_q <= fler_set_c || (fler_q && swe_q);
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            ebr_q <= FMC_ERASE_BLK_RST;
        end else if (!swe_q) begin
            ebr_q <= '0;
        end else if (wr_ebr) begin
            ebr_q <= wd_c;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            wait_state_control_q <= FMC_WAIT_STATE_RST;
        end else if (commit_c && idx_c == FMC_IDX_WAIT_STATE) begin
            wait_state_control_q <= wd_c;
        end
    end

    // The mode pins are caught on the first edge after reset, not under the reset itself.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            init_q <= 1'b0;
            expanded_mode_enable_q <= 1'b0;
        end else if (!init_q || mode1_c) begin
            init_q <= 1'b1;
            expanded_mode_enable_q <= mode1_c;
        end else if (wr_md && boot_mode) begin
            expanded_mode_enable_q <= wd_c[FMC_MD_EXPANDED_MODE_ENABLE];
        end
    end

    // ===========================================================
    // Register read, captured on the edge that takes the request
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            avs_readdata <= '0;
        end else if (take_c) begin
            avs_readdata <= '0;
            unique case (idx_c)
                FMC_IDX_CTRL_ONE: if (flash_acc_c) begin
                    avs_readdata[7:0] <= {FMC_CTRL_ONE_RST[FMC_C1_FWE], swe_q, 2'b00, ev_q, pv_q, e_q, p_q};
                end
                FMC_IDX_CTRL_TWO: if (flash_acc_c && swe_q) begin
                    avs_readdata[7:0] <= {fler_q, 5'b00000, esu_q, psu_q};
                end
                FMC_IDX_ERASE_BLK: if (flash_acc_c) begin
                    avs_readdata[7:0] <= ebr_q;
                end
                FMC_IDX_WAIT_STATE: avs_readdata[7:0] <= wait_state_control_q;
                FMC_IDX_MODE_CTRL: begin
                    avs_readdata[7:0] <= {expanded_mode_enable_q, FMC_MD_FIXED[4:0], mode_pin_hi, mode_pin_lo};
                end
                default: avs_readdata <= '0;
            endcase
        end
    end

    // ===========================================================
    // Array, program group buffer and erase walker
    logic [15:0] mem [ROM_WORDS];
    logic [15:0] grp_buf_q [FMC_GROUP_WORDS];
    logic [AW-5:0] grp_base_q;
    logic [AW-1:0] er_ptr_q;
    logic buf_wr_c;

    function automatic logic [2:0] fmc_block_of(input logic [15:0] byte_addr);
        logic [2:0] b;
        b = 3'd0;
        for (int i = 1; i < 8; i++) begin
            if (byte_addr >= FMC_BLK_BASE[i]) begin
                b = 3'(i);
            end
        end
        return b;
    endfunction

    // Group writes are gathered only while program setup is armed.
    assign buf_wr_c = rom_req && rom_we && psu_q && !p_q && !clr_modes_c;

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            grp_base_q <= '0;
            for (int i = 0; i < FMC_GROUP_WORDS; i++) begin
                grp_buf_q[i] <= FMC_WORD_ERASED;
            end
        end else if (commit_prog_c) begin
            for (int i = 0; i < FMC_GROUP_WORDS; i++) begin
                grp_buf_q[i] <= FMC_WORD_ERASED;
            end
        end else if (buf_wr_c) begin
            grp_base_q <= rom_addr[AW:5];
            if (rom_word) begin
                grp_buf_q[rom_addr[4:1]] <= rom_wdata;
            end else if (!rom_addr[0]) begin
                grp_buf_q[rom_addr[4:1]][15:8] <= rom_wdata[15:8];
            end else begin
                grp_buf_q[rom_addr[4:1]][7:0] <= rom_wdata[7:0];
            end
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            er_ptr_q <= '0;
        end else if (e_q) begin
            er_ptr_q <= (int'(er_ptr_q) == ROM_WORDS - 1) ? '0 : er_ptr_q + AW'(1);
        end else begin
            er_ptr_q <= '0;
        end
    end

    // Programming can only clear bits, so the whole group lands in one edge.
    always_ff @(posedge clock) begin
        if (commit_prog_c) begin
            for (int i = 0; i < FMC_GROUP_WORDS; i++) begin
                mem[{grp_base_q, 4'(i)}] <= mem[{grp_base_q, 4'(i)}] & grp_buf_q[i];
            end
        end else if (e_q && ebr_q[fmc_block_of(16'({er_ptr_q, 1'b0}))]) begin
            mem[er_ptr_q] <= FMC_WORD_ERASED;
        end
    end

    // ===========================================================
    // CPU read port: request in the first state, data in the second
    logic [15:0] rd_word_c;
    assign rd_word_c = (int'(rom_addr[15:1]) < ROM_WORDS) ? mem[rom_addr[AW:1]] : '0;

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            rom_ack <= 1'b0;
            rom_rdata <= '0;
        end else begin
            rom_ack <= rom_req;
            if (rom_req && !rom_we) begin
                if (!rom_en_c) begin
                    rom_rdata <= '0;
                end else if (rom_word) begin
                    rom_rdata <= rd_word_c;
                end else if (!rom_addr[0]) begin
                    rom_rdata <= {rd_word_c[15:8], 8'h00};
                end else begin
                    rom_rdata <= {8'h00, rd_word_c[7:0]};
                end
            end
        end
    end

    // ===========================================================
    // Status outputs
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            rom_enabled <= 1'b0;
            expanded_mode <= 1'b0;
            hw_protect <= 1'b1;
            sw_protect <= 1'b1;
            err_protect <= 1'b0;
            op_mode <= FMC_OP_IDLE;
        end else begin
            rom_enabled <= rom_en_c;
            expanded_mode <= mode1_c || (mode_pin_hi && !mode_pin_lo) || expanded_mode_enable_q;
            hw_protect <= prot_hw_c;
            sw_protect <= !swe_q;
            err_protect <= fler_q;
            if (p_q) begin
                op_mode <= FMC_OP_PROGRAM;
            end else if (e_q) begin
                op_mode <= FMC_OP_ERASE;
            end else if (pv_q) begin
                op_mode <= FMC_OP_PROG_VERIFY;
            end else if (ev_q) begin
                op_mode <= FMC_OP_ERASE_VERIFY;
            end else begin
                op_mode <= FMC_OP_IDLE;
            end
        end
    end

    // ===========================================================
    // Boot bit rate measurement: the host opens with a zero byte, nine bit times low
    fmc_baud_e baud_st_q;
    logic [BAUD_W-1:0] baud_cnt_q;

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            baud_st_q <= FMC_BAUD_IDLE;
            baud_cnt_q <= '0;
            baud_period <= '0;
            baud_locked <= 1'b0;
        end else begin
            unique case (baud_st_q)
                FMC_BAUD_IDLE: begin
                    baud_locked <= 1'b0;
                    if (boot_mode && !boot_rxd) begin
                        baud_st_q <= FMC_BAUD_MEASURE;
                        baud_cnt_q <= BAUD_W'(1);
                    end
                end
                FMC_BAUD_MEASURE: begin
                    if (!boot_mode) begin
                        baud_st_q <= FMC_BAUD_IDLE;
                    end else if (boot_rxd) begin
                        baud_period <= baud_cnt_q / BAUD_W'(FMC_BAUD_LOW_BITS);
                        baud_locked <= 1'b1;
                        baud_st_q <= FMC_BAUD_LOCKED;
                    end else if (!(&baud_cnt_q)) begin
                        baud_cnt_q <= baud_cnt_q + BAUD_W'(1);
                    end
                end
                FMC_BAUD_LOCKED: begin
                    if (!boot_mode) begin
                        baud_st_q <= FMC_BAUD_IDLE;
                    end
                end
            endcase
        end
    end

    // ===========================================================
    // Assertions
    default clocking @(posedge clock); endclocking
    default disable iff (rst);

    a_rom_two_state: assert property (rom_req |=> rom_ack)
        else $error("ROM access did not complete in two states");
    a_byte_lane_even: assert property (rom_req && !rom_we && !rom_word && !rom_addr[0] |=> rom_rdata[7:0] == 8'h00)
        else $error("Even byte not on upper lines");
    a_byte_lane_odd: assert property (rom_req && !rom_we && !rom_word && rom_addr[0] |=> rom_rdata[15:8] == 8'h00)
        else $error("Odd byte not on lower lines");
    a_mode1_rom_off: assert property (mode1_c |=> !rom_enabled && (rom_rdata == 16'h0000 || !$past(rom_req)))
        else $error("ROM enabled in mode 1");
    a_mode23_rom_on: assert property (!$past(rst) && mode_pin_hi |=> rom_enabled)
        else $error("ROM disabled in mode 2 or 3");
    a_off_reads_zero: assert property (take_c && !rom_en_c && idx_c[15:2] == FMC_IDX_CTRL_ONE[15:2]
        |=> avs_readdata == 32'h0000_0000)
        else $error("Flash register read non-zero with ROM disabled");
    a_swe_holds_zero: assert property (!swe_q |=> !esu_q && !psu_q && ebr_q == 8'h00)
        else $error("Setup or erase select not held at zero");
    a_mode_read_bits: assert property (take_c && idx_c == FMC_IDX_MODE_CTRL
        |=> avs_readdata[6:0] == {FMC_MD_FIXED[4:0], $past(mode_pin_hi), $past(mode_pin_lo)})
        else $error("Mode control read pattern wrong");
    a_erase_gated: assert property ($rose(e_q) |-> $past(esu_q && swe_q && wr_c1))
        else $error("Erase set without setup");
    a_user_refused: assert property ((!boot_mode && !user_program_mode) [*2] |-> !p_q && !e_q)
        else $error("Program or erase active in user mode");
    a_mode1_expanded_mode_enable: assert property (init_q && mode1_c |=> expanded_mode_enable_q)
        else $error("Expanded bit not one in mode 1");

    c_group_program: cover property (commit_prog_c);
    c_block_erase: cover property (e_q && ebr_q != 8'h00);
    c_baud_lock: cover property ($rose(baud_locked));
    c_mode_read: cover property (take_c && idx_c == FMC_IDX_MODE_CTRL);

endmodule // fmc_flash_ctrl

// File: src/fmc_pkg.sv
// Purpose: Shared constants and types for the flash ROM access and mode control block.
// Assumes: Registers are byte wide and sit in the low byte of a 32-bit Avalon word.
// Notes: Register byte address is four times the register index below.
package fmc_pkg;

    // ===========================================================
    // Register indices (byte address = index * 4)
    localparam logic [15:0] FMC_IDX_CTRL_ONE = 16'hFF80;
    localparam logic [15:0] FMC_IDX_CTRL_TWO = 16'hFF81;
    localparam logic [15:0] FMC_IDX_ERASE_BLK = 16'hFF83;
    localparam logic [15:0] FMC_IDX_WAIT_STATE = 16'hFFC2;
    localparam logic [15:0] FMC_IDX_MODE_CTRL = 16'hFFC5;

    // ===========================================================
    // Reset values
    localparam logic [7:0] FMC_CTRL_ONE_RST = 8'h80;
    localparam logic [7:0] FMC_CTRL_TWO_RST = 8'h00;
    localparam logic [7:0] FMC_ERASE_BLK_RST = 8'h00;
    localparam logic [7:0] FMC_WAIT_STATE_RST = 8'h08;

    // ===========================================================
    // Field positions
    localparam int FMC_C1_FWE = 7;
    localparam int FMC_C1_SWE = 6;
    localparam int FMC_C1_EV = 3;
    localparam int FMC_C1_PV = 2;
    localparam int FMC_C1_E = 1;
    localparam int FMC_C1_P = 0;
    localparam int FMC_C2_FLER = 7;
    localparam int FMC_C2_ESU = 1;
    localparam int FMC_C2_PSU = 0;
    localparam int FMC_WS_FLASH_SEL = 7;
    localparam int FMC_MD_EXPANDED_MODE_ENABLE = 7;
    // Operating mode control bits 6, 5 and 2 read one, bits 4 and 3 read zero.
    localparam logic [5:0] FMC_MD_FIXED = 6'h19;

    // ===========================================================
    // Array geometry and timing
    localparam int FMC_GROUP_WORDS = 16;
    localparam logic [15:0] FMC_BLK_BASE [0:7] = '{16'h0000, 16'h0400, 16'h0800, 16'h0C00,
                                                    16'h1000, 16'h1800, 16'h4800, 16'h8800};
    localparam logic [15:0] FMC_WORD_ERASED = 16'hFFFF;
    localparam int FMC_BAUD_LOW_BITS = 9;

    // ===========================================================
    // Types
    typedef enum logic [2:0] {FMC_OP_IDLE, FMC_OP_PROGRAM, FMC_OP_PROG_VERIFY, FMC_OP_ERASE,
                              FMC_OP_ERASE_VERIFY} fmc_op_e;
    typedef enum logic [1:0] {FMC_BAUD_IDLE, FMC_BAUD_MEASURE, FMC_BAUD_LOCKED} fmc_baud_e;

endpackage

// File: test/fmc_cpu_model.sv
// Purpose: CPU side of the ROM port, driven by calls from the bench.
// Assumes: One access at a time; the bench waits for each to finish.
// Notes: Released address and data lines toggle so stale values never pass.
`timescale 1ns/1ns
module fmc_cpu_model (
    // Clock
    input wire logic clock,
    // ROM port
    output logic rom_req,
    output logic rom_we,
    output logic rom_word,
    output logic [15:0] rom_addr,
    output logic [15:0] rom_wdata,
    input wire logic [15:0] rom_rdata,
    input wire logic rom_ack
);
    // ===========================================================
    // Access
    initial begin
        rom_req = 1'b0;
        rom_we = 1'b0;
        rom_word = 1'b0;
        rom_addr = 16'h0000;
        rom_wdata = 16'h0000;
    end

    task automatic access(input logic we, input logic word, input logic [15:0] addr, input logic [15:0] wd,
                          output logic [15:0] rd, output logic ok);
        @(posedge clock);
        rom_req <= 1'b1;
        rom_we <= we;
        rom_word <= word;
        rom_addr <= word ? {addr[15:1], 1'b0} : addr;
        rom_wdata <= wd;
        @(posedge clock);
        rom_req <= 1'b0;
        rom_addr <= ~addr;
        rom_wdata <= ~wd;
        @(posedge clock);
        ok = rom_ack;
        rd = rom_rdata;
    endtask
endmodule // fmc_cpu_model

// File: test/testbench.sv
// Purpose: Self-checking bench for the flash access and mode control block.
// Assumes: Short array so an erase pass fits in a few hundred cycles.
// Notes: Each reset restarts the mode pins; the array is erased before programming.
`timescale 1ns/1ns
module testbench;
    import fmc_pkg::*;
    logic clock = 1'b0;
    logic rst, avs_read, avs_write, avs_waitrequest, mode_pin_hi, mode_pin_lo, boot_mode, upm;
    logic rom_req, rom_we, rom_word, rom_ack, rom_enabled, hw_protect, ok;
    logic sw_protect, err_protect, expanded_mode, baud_locked, rxd;
    logic [19:0] baud_period;
    logic [17:0] avs_address;
    logic [31:0] avs_writedata, avs_readdata;
    logic [15:0] rom_addr, rom_wdata, rom_rdata, r;
    fmc_op_e op_mode;
    int bad_count = 0;
    int samples_checked = 0;

    always #2 clock = ~clock;

    fmc_flash_ctrl #(.ROM_WORDS(256)) i_dut (.clock(clock), .rst(rst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hF),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .mode_pin_hi(mode_pin_hi),
        .mode_pin_lo(mode_pin_lo), .boot_mode(boot_mode), .user_program_mode(upm), .rom_req(rom_req),
        .rom_we(rom_we), .rom_word(rom_word), .rom_addr(rom_addr), .rom_wdata(rom_wdata),
        .rom_rdata(rom_rdata), .rom_ack(rom_ack), .boot_rxd(rxd), .rom_enabled(rom_enabled),
        .expanded_mode(expanded_mode), .op_mode(op_mode), .hw_protect(hw_protect), .sw_protect(sw_protect),
        .err_protect(err_protect), .baud_period(baud_period), .baud_locked(baud_locked));

    fmc_cpu_model i_cpu (.clock(clock), .rom_req(rom_req), .rom_we(rom_we), .rom_word(rom_word),
        .rom_addr(rom_addr), .rom_wdata(rom_wdata), .rom_rdata(rom_rdata), .rom_ack(rom_ack));

    // ===========================================================
    // Shared tasks
    task automatic give_verdict();
        if (bad_count == 0 && samples_checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp) begin
            $display("FAIL %0t got %h expected %h", $time, got, exp);
            bad_count++;
        end
    endtask

    // An edge passes before each request so no strobe is driven twice in one step.
    task automatic bus(input logic wr, input logic [15:0] idx, input logic [7:0] wd, output logic [7:0] rd);
        int n;
        n = 0;
        @(posedge clock);
        avs_address <= {idx, 2'b00};
        avs_writedata <= {24'h000000, wd};
        avs_write <= wr;
        avs_read <= !wr;
        @(posedge clock);
        while (avs_waitrequest !== 1'b0) begin
            if (n == 20) begin
                $display("FAIL %0t bus timeout", $time);
                bad_count++;
                give_verdict();
            end
            n++;
            @(posedge clock);
        end
        rd = avs_readdata[7:0];
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask

    task automatic wr(input logic [15:0] idx, input logic [7:0] d);
        logic [7:0] x;
        bus(1'b1, idx, d, x);
    endtask

    task automatic rchk(input logic [15:0] idx, input logic [7:0] exp);
        logic [7:0] x;
        bus(1'b0, idx, 8'h00, x);
        chk({8'h00, x}, {8'h00, exp});
    endtask

    task automatic restart(input logic hi, input logic lo);
        rst <= 1'b1;
        mode_pin_hi <= hi;
        mode_pin_lo <= lo;
        repeat (4) @(posedge clock);
        rst <= 1'b0;
        repeat (2) @(posedge clock);
    endtask

    // ===========================================================
    // Main sequence
    initial begin
        rst = 1'b1;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_address = 18'h00000;
        avs_writedata = 32'h00000000;
        mode_pin_hi = 1'b1;
        mode_pin_lo = 1'b0;
        boot_mode = 1'b1;
        upm = 1'b0;
        rxd = 1'b1;
        restart(1'b1, 1'b0);
        chk(16'(rom_enabled), 16'h0001);
        chk(16'(hw_protect), 16'h0000);
        chk(16'(sw_protect), 16'h0001);
        // The host opens with ninety cycles low, nine bit times of ten cycles.
        rxd <= 1'b0;
        repeat (90) @(posedge clock);
        rxd <= 1'b1;
        repeat (2) @(posedge clock);
        chk(16'(baud_period), 16'(90 / FMC_BAUD_LOW_BITS));
        chk(16'(baud_locked), 16'h0001);
        rchk(FMC_IDX_WAIT_STATE, FMC_WAIT_STATE_RST);
        rchk(FMC_IDX_CTRL_ONE, 8'h00);
        rchk(FMC_IDX_MODE_CTRL, 8'h66);
        wr(FMC_IDX_MODE_CTRL, 8'h9B);
        rchk(FMC_IDX_MODE_CTRL, 8'hE6);
        wr(FMC_IDX_MODE_CTRL, 8'h00);
        wr(FMC_IDX_WAIT_STATE, 8'h88);
        rchk(FMC_IDX_CTRL_ONE, FMC_CTRL_ONE_RST);
        wr(FMC_IDX_CTRL_TWO, 8'h01);
        rchk(FMC_IDX_CTRL_TWO, 8'h00);
        wr(FMC_IDX_CTRL_ONE, 8'h41);
        rchk(FMC_IDX_CTRL_ONE, 8'hC0);
        wr(FMC_IDX_CTRL_TWO, 8'h02);
        wr(FMC_IDX_ERASE_BLK, 8'h01);
        rchk(FMC_IDX_ERASE_BLK, 8'h01);
        wr(FMC_IDX_CTRL_ONE, 8'h42);
        repeat (2) @(posedge clock);
        chk(16'(op_mode), 16'(FMC_OP_ERASE));
        repeat (300) @(posedge clock);
        wr(FMC_IDX_CTRL_ONE, 8'h40);
        wr(FMC_IDX_CTRL_TWO, 8'h01);
        i_cpu.access(1'b1, 1'b1, 16'h0000, 16'hA55A, r, ok);
        wr(FMC_IDX_CTRL_ONE, 8'h41);
        repeat (2) @(posedge clock);
        chk(16'(op_mode), 16'(FMC_OP_PROGRAM));
        wr(FMC_IDX_CTRL_ONE, 8'h40);
        i_cpu.access(1'b0, 1'b1, 16'h0000, 16'h0000, r, ok);
        chk(r, 16'hA55A);
        chk(16'(ok), 16'h0001);
        i_cpu.access(1'b0, 1'b0, 16'h0000, 16'h0000, r, ok);
        chk(r, 16'hA500);
        i_cpu.access(1'b0, 1'b0, 16'h0001, 16'h0000, r, ok);
        chk(r, 16'h005A);
        wr(FMC_IDX_CTRL_ONE, 8'h44);
        repeat (2) @(posedge clock);
        chk(16'(op_mode), 16'(FMC_OP_PROG_VERIFY));
        wr(FMC_IDX_CTRL_ONE, 8'h48);
        repeat (2) @(posedge clock);
        chk(16'(op_mode), 16'(FMC_OP_ERASE_VERIFY));
        // Reading the array while program is set must raise the error flag.
        wr(FMC_IDX_CTRL_ONE, 8'h41);
        i_cpu.access(1'b0, 1'b1, 16'h0000, 16'h0000, r, ok);
        @(posedge clock);
        chk(16'(err_protect), 16'h0001);
        rchk(FMC_IDX_CTRL_TWO, 8'h80);
        wr(FMC_IDX_CTRL_ONE, 8'h00);
        wr(FMC_IDX_CTRL_ONE, 8'h40);
        boot_mode <= 1'b0;
        repeat (2) @(posedge clock);
        chk(16'(hw_protect), 16'h0001);
        wr(FMC_IDX_CTRL_TWO, 8'h01);
        i_cpu.access(1'b1, 1'b1, 16'h0000, 16'h0000, r, ok);
        wr(FMC_IDX_CTRL_ONE, 8'h41);
        i_cpu.access(1'b0, 1'b1, 16'h0000, 16'h0000, r, ok);
        chk(r, 16'hA55A);
        restart(1'b0, 1'b1);
        chk(16'(rom_enabled), 16'h0000);
        chk(16'(expanded_mode), 16'h0001);
        rchk(FMC_IDX_MODE_CTRL, 8'hE5);
        wr(FMC_IDX_WAIT_STATE, 8'h88);
        wr(FMC_IDX_CTRL_ONE, 8'h40);
        rchk(FMC_IDX_CTRL_ONE, 8'h00);
        i_cpu.access(1'b0, 1'b1, 16'h0000, 16'h0000, r, ok);
        chk(r, 16'h0000);
        restart(1'b1, 1'b1);
        chk(16'(rom_enabled), 16'h0001);
        chk(16'(expanded_mode), 16'h0000);
        rchk(FMC_IDX_MODE_CTRL, 8'h67);
        rchk(16'hFF84, 8'h00);
        give_verdict();
    end
endmodule // testbench
